// File: supply_prot_pkg.sv
// Shared constants for the supply output protection controller.
// Summary of operation
// [R01] Hold constant voltage, current or power priority and read back the selection.
// [R02] Fault clear command resets the latched faults that forced the output off.
// [R03] Overvoltage, overcurrent, overpower, overtemperature, mains faults always latch.
// [R04] Clear succeeds only when every fault cause is gone; host removes causes first.
// [R05] After a clear the output returns to its on or off state before the fault.
// [R06] Fire command triggers only while armed; host checks the waiting flag.
// [R07] Trigger after single initiate applies triggered values and clears waiting flag.
// [R08] With continuous initiation the system re-arms after each trigger, waiting set.
// [R09] Only the bus trigger source exists and status always reports it.
// [R10] Current setpoint accepts zero to 105 percent of rated current.
// [R11] Setpoint readback returns the programmed output current.
// [R12] Fixed mode: immediate setpoint drives output; step mode: only triggered value.
// [R13] Trip delay 0.05 to 65.535 s; trip waits that delay before acting.
// [R14] Delay readback returns the programmed trip delay.
// [R15] Threshold accepts up to 110 percent of rated; readback returns it.
// [R16] Minimum threshold keyword gives 10 percent of rated current.
// [R17] Instrument reset sets the threshold to its maximum value.
// [R18] Remotely programmed threshold stays in force in local operation.
// [R19] Guard enabled: output switches off when current exceeds the threshold.
// [R20] Guard enable is a single bit reading 1 enabled, 0 disabled.
// [R21] Output enable bit turns the output on or off and reads back.
// [R22] Delay timer restarts whenever current falls back, trips only on expiry.
// [R23] Out of range setpoint or threshold writes are rejected, value kept.
package supply_prot_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_AMP_SET = 8'h08;
    localparam logic [7:0] ADDR_TRIG_AMP = 8'h0c;
    localparam logic [7:0] ADDR_TRIG_VOLT = 8'h10;
    localparam logic [7:0] ADDR_OC_THRESH = 8'h14;
    localparam logic [7:0] ADDR_OC_DELAY = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;
    localparam logic [7:0] ADDR_OUT_AMP = 8'h20;
    localparam logic [7:0] ADDR_OUT_VOLT = 8'h24;
    // Control register fields.
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_PRIO_LO = 1;
    localparam int CTRL_GUARD = 3;
    localparam int CTRL_STEP = 4;
    localparam int CTRL_CONT = 5;
    // Command register bits, each a write-one pulse.
    localparam int CMD_CLEAR = 0;
    localparam int CMD_INIT = 1;
    localparam int CMD_FIRE = 2;
    localparam int CMD_RESET = 3;
    localparam int CMD_THR_MIN = 4;
    // Status fields.
    localparam int ST_ON = 0;
    localparam int ST_WAIT = 1;
    localparam int ST_FAULT_LO = 2;
    localparam int ST_SRC_BUS = 7;
    localparam int NUM_FAULTS = 5;
    localparam int F_OV = 0;
    localparam int F_OC = 1;
    localparam int F_OP = 2;
    localparam int F_OT = 3;
    localparam int F_AC = 4;
    typedef enum logic [1:0] {
        constant_voltage_priority = 2'b00,
        constant_current_priority = 2'b01,
        constant_power_priority = 2'b10
    } priority_mode_select_t;
    localparam int AMP_SET_PCT = 105;
    localparam int THR_MAX_PCT = 110;
    localparam int THR_MIN_PCT = 10;
    localparam int PCT_BASE = 100;
    localparam int DELAY_MIN_MS = 50;
    localparam int DELAY_MAX_MS = 65535;
    localparam int CLK_MHZ = 250;
    localparam int MS_PER_S = 1000;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
endpackage : supply_prot_pkg

// File: oc_trip_timer.sv
// Overcurrent trip delay timer counting whole milliseconds.
`timescale 1ns/10ps
module oc_trip_timer #(
    parameter int CYC_PER_MS = 250000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic over,
    input wire logic [15:0] delay_ms,
    output logic trip
);
    logic [17:0] pre_q;
    logic [15:0] ms_q;
    logic tick;

    assign tick = (pre_q == 18'(CYC_PER_MS - 1));

    // Any dip below threshold restarts the full delay so brief spikes never trip.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 18'h0;
        end else if (!over || tick) begin // R22
            pre_q <= 18'h0;
        end else begin
            pre_q <= pre_q + 18'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_q <= 16'h0;
        end else if (!over) begin // R22
            ms_q <= 16'h0;
        end else if (tick && ms_q != delay_ms) begin
            ms_q <= ms_q + 16'h1;
        end
    end

    assign trip = over && (ms_q == delay_ms); // R13
endmodule : oc_trip_timer

// File: supply_output_protection_control.sv
// Protection, trigger and setpoint control with an APB register file.
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/10ps
module supply_output_protection_control
    import supply_prot_pkg::*;
#(
    parameter logic [15:0] RATED_AMP = 16'd1000,
    parameter int CYC_MS = supply_prot_pkg::CYC_PER_MS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ov_cond,
    input wire logic op_cond,
    input wire logic ot_cond,
    input wire logic ac_fail_cond,
    input wire logic [15:0] meas_amp,
    output logic supply_on,
    output logic [1:0] priority_mode,
    output logic [15:0] amp_program,
    output logic [15:0] volt_program
);
    import supply_prot_pkg::*;

    localparam logic [15:0] AMP_MAX = 16'((32'(RATED_AMP) * AMP_SET_PCT) / PCT_BASE);
    localparam logic [15:0] THR_MAX = 16'((32'(RATED_AMP) * THR_MAX_PCT) / PCT_BASE);
    localparam logic [15:0] THR_MIN = 16'((32'(RATED_AMP) * THR_MIN_PCT) / PCT_BASE);

    logic [3:0] s1_q, s2_q;
    logic en_q, guard_q, step_q, cont_q, wait_q;
    priority_mode_select_t prio_q;
    logic [15:0] amp_set_q, trig_amp_q, trig_volt_q, thr_q, dly_q;
    logic [15:0] amp_out_q, volt_out_q;
    logic [NUM_FAULTS-1:0] fault_q, cause;
    logic wr, rd_setup, trip, over, clear_ok, fire;
    logic val_ok;
    logic [15:0] wv;
    logic [31:0] rdata;

    // Fault inputs come from the power stage, outside this clock domain.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
        end else begin
            s1_q <= {ac_fail_cond, ot_cond, op_cond, ov_cond};
            s2_q <= s1_q;
        end
    end

    assign wr = psel && penable && pready && pwrite;
    assign rd_setup = psel && !penable;
    assign wv = pwdata[15:0];
    assign over = guard_q && (meas_amp > thr_q); // R19
    assign cause = {s2_q[3], s2_q[2], s2_q[1], over, s2_q[0]};
    assign clear_ok = (cause == '0); // R04
    assign fire = wr && paddr == ADDR_CMD && pwdata[CMD_FIRE] && wait_q; // R06

    oc_trip_timer #(
        .CYC_PER_MS(CYC_MS)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .over(over),
        .delay_ms(dly_q),
        .trip(trip)
    );

    always_comb begin
        val_ok = 1'b1;
        case (paddr)
            ADDR_AMP_SET, ADDR_TRIG_AMP: val_ok = (wv <= AMP_MAX); // R10 R23
            ADDR_OC_THRESH: val_ok = (wv <= THR_MAX); // R15 R23
            ADDR_OC_DELAY: val_ok = (wv >= 16'(DELAY_MIN_MS)); // R13 R23
            ADDR_CTRL: val_ok = (wv[CTRL_PRIO_LO+:2] != 2'b11);
            default: val_ok = 1'b1;
        endcase
    end

    // Registers answer in the first access cycle, so every transfer has one access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= rd_setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (rd_setup) begin
            pslverr <= (paddr > ADDR_OUT_VOLT) || (paddr[1:0] != 2'b00) ||
                       (pwrite && !val_ok);
        end else begin
            pslverr <= 1'b0;
        end
    end

    always_comb begin
        rdata = 32'h0;
        case (paddr)
            ADDR_CTRL: rdata = {26'h0, cont_q, step_q, guard_q, prio_q, en_q}; // R01 R20 R21
            ADDR_AMP_SET: rdata = {16'h0, amp_set_q}; // R11
            ADDR_TRIG_AMP: rdata = {16'h0, trig_amp_q};
            ADDR_TRIG_VOLT: rdata = {16'h0, trig_volt_q};
            ADDR_OC_THRESH: rdata = {16'h0, thr_q}; // R15
            ADDR_OC_DELAY: rdata = {16'h0, dly_q}; // R14
            ADDR_STATUS: rdata = {24'h0, 1'b1, fault_q, wait_q, supply_on}; // R09
            ADDR_OUT_AMP: rdata = {16'h0, amp_out_q};
            ADDR_OUT_VOLT: rdata = {16'h0, volt_out_q};
            default: rdata = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_setup && !pwrite) begin
            prdata <= rdata;
        end
    end

    // The enable bit keeps its value through a fault; that is what restores the output.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 1'b0;
            guard_q <= 1'b0;
            step_q <= 1'b0;
            cont_q <= 1'b0;
            prio_q <= constant_voltage_priority;
        end else if (wr && paddr == ADDR_CTRL && val_ok) begin
            en_q <= pwdata[CTRL_ENABLE]; // R21
            prio_q <= priority_mode_select_t'(pwdata[CTRL_PRIO_LO+:2]); // R01
            guard_q <= pwdata[CTRL_GUARD]; // R20
            step_q <= pwdata[CTRL_STEP]; // R12
            cont_q <= pwdata[CTRL_CONT]; // R08
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amp_set_q <= 16'h0;
            trig_amp_q <= 16'h0;
            trig_volt_q <= 16'h0;
            dly_q <= 16'(DELAY_MIN_MS);
        end else if (wr && val_ok) begin // R23
            if (paddr == ADDR_AMP_SET) begin
                amp_set_q <= wv; // R10
            end
            if (paddr == ADDR_TRIG_AMP) begin
                trig_amp_q <= wv;
            end
            if (paddr == ADDR_TRIG_VOLT) begin
                trig_volt_q <= wv;
            end
            if (paddr == ADDR_OC_DELAY) begin
                dly_q <= wv; // R13
            end
        end
    end

    // Held across local operation; only bus writes and resets touch it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_q <= THR_MAX;
        end else if (wr && paddr == ADDR_CMD && pwdata[CMD_RESET]) begin
            thr_q <= THR_MAX; // R17
        end else if (wr && paddr == ADDR_CMD && pwdata[CMD_THR_MIN]) begin
            thr_q <= THR_MIN; // R16
        end else if (wr && paddr == ADDR_OC_THRESH && val_ok) begin
            thr_q <= wv; // R15 R18
        end
    end

    // A fault that arrives with the clear stays latched.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_q <= '0;
        end else begin
            if (wr && paddr == ADDR_CMD && pwdata[CMD_CLEAR] && clear_ok) begin
                fault_q <= '0; // R02 R04
            end
            if (s2_q[0]) fault_q[F_OV] <= 1'b1; // R03
            if (trip) fault_q[F_OC] <= 1'b1; // R03 R19
            if (s2_q[1]) fault_q[F_OP] <= 1'b1; // R03
            if (s2_q[2]) fault_q[F_OT] <= 1'b1; // R03
            if (s2_q[3]) fault_q[F_AC] <= 1'b1; // R03
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 1'b0;
        end else if (fire) begin
            wait_q <= cont_q; // R07 R08
        end else if ((wr && paddr == ADDR_CMD && pwdata[CMD_INIT]) || cont_q) begin
            wait_q <= 1'b1; // R08
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amp_out_q <= 16'h0;
            volt_out_q <= 16'h0;
        end else if (fire) begin
            volt_out_q <= trig_volt_q; // R07
            if (step_q) amp_out_q <= trig_amp_q; // R07 R12
        end else if (!step_q) begin
            amp_out_q <= amp_set_q; // R12
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_on <= 1'b0;
            priority_mode <= 2'b00;
            amp_program <= 16'h0;
            volt_program <= 16'h0;
        end else begin
            supply_on <= en_q && (fault_q == '0) && !trip; // R05 R19 R21
            priority_mode <= prio_q; // R01
            amp_program <= amp_out_q;
            volt_program <= volt_out_q;
        end
    end

    sequence s_fire;
        fire;
    endsequence

    property p_fire_apply;
        @(posedge pclk) disable iff (!presetn)
        s_fire |=> (volt_out_q == $past(trig_volt_q)) ##1 (volt_program == $past(volt_out_q));
    endproperty
    a_fire_apply: assert property (p_fire_apply) else $error("trigger value not applied"); // R07

    property p_wait_after_fire;
        @(posedge pclk) disable iff (!presetn)
        s_fire |=> (wait_q == $past(cont_q));
    endproperty
    a_wait_after_fire: assert property (p_wait_after_fire) else $error("wait flag wrong"); // R08

    property p_trip_off;
        @(posedge pclk) disable iff (!presetn)
        trip |=> fault_q[F_OC] && !supply_on;
    endproperty
    a_trip_off: assert property (p_trip_off) else $error("overcurrent did not trip"); // R19

    property p_fault_off;
        @(posedge pclk) disable iff (!presetn)
        (fault_q != '0) |=> !supply_on;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("output on with fault"); // R03

    property p_clear_blocked;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == ADDR_CMD && pwdata[CMD_CLEAR] && !clear_ok && fault_q != '0)
        |=> (fault_q != '0);
    endproperty
    a_clear_blocked: assert property (p_clear_blocked) else $error("clear with cause"); // R04

    property p_restore;
        @(posedge pclk) disable iff (!presetn)
        $fell(fault_q != '0) && !trip |=> (supply_on == $past(en_q));
    endproperty
    a_restore: assert property (p_restore) else $error("output not restored"); // R05

    property p_reject;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == ADDR_OC_THRESH && wv > THR_MAX) |=> $stable(thr_q);
    endproperty
    a_reject: assert property (p_reject) else $error("bad threshold stored"); // R23

    property p_no_fire_idle;
        @(posedge pclk) disable iff (!presetn)
        (!wait_q && !cont_q) |=> $stable(volt_out_q);
    endproperty
    a_no_fire_idle: assert property (p_no_fire_idle) else $error("fired unarmed"); // R06

    property p_amp_limit;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |-> (amp_set_q <= AMP_MAX) && (thr_q <= THR_MAX) && (dly_q >= 16'(DELAY_MIN_MS));
    endproperty
    a_amp_limit: assert property (p_amp_limit) else $error("value out of range"); // R10

    property p_reset_thr;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == ADDR_CMD && pwdata[CMD_RESET]) |=> (thr_q == THR_MAX);
    endproperty
    a_reset_thr: assert property (p_reset_thr) else $error("reset left threshold"); // R17

    sequence s_ctrl_write;
        wr && paddr == ADDR_CTRL && val_ok;
    endsequence

    property p_src_bus;
        @(posedge pclk) disable iff (!presetn)
        (rd_setup && !pwrite && paddr == ADDR_STATUS) |=> prdata[ST_SRC_BUS];
    endproperty
    a_src_bus: assert property (p_src_bus) else $error("trigger source not bus"); // R09

    property p_fix_follow;
        @(posedge pclk) disable iff (!presetn)
        (!step_q && !fire) |=> (amp_out_q == $past(amp_set_q));
    endproperty
    a_fix_follow: assert property (p_fix_follow) else $error("fixed current not applied"); // R12

    // In step mode only a fire may move the applied current.
    property p_step_hold;
        @(posedge pclk) disable iff (!presetn)
        (step_q && !fire) |=> $stable(amp_out_q);
    endproperty
    a_step_hold: assert property (p_step_hold) else $error("step current moved"); // R12

    property p_thr_min;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == ADDR_CMD && pwdata[CMD_THR_MIN] && !pwdata[CMD_RESET])
        |=> (thr_q == THR_MIN);
    endproperty
    a_thr_min: assert property (p_thr_min) else $error("minimum threshold not set"); // R16

    property p_guard_write;
        @(posedge pclk) disable iff (!presetn)
        s_ctrl_write |=> (guard_q == $past(pwdata[CTRL_GUARD]));
    endproperty
    a_guard_write: assert property (p_guard_write) else $error("guard enable not stored"); // R20

    property p_enable_off;
        @(posedge pclk) disable iff (!presetn)
        !en_q |=> !supply_on;
    endproperty
    a_enable_off: assert property (p_enable_off) else $error("output on while disabled"); // R21

    // A dip below threshold must clear the count, so no trip can follow at once.
    property p_timer_restart;
        @(posedge pclk) disable iff (!presetn)
        !over |=> !trip;
    endproperty
    a_timer_restart: assert property (p_timer_restart) else $error("trip without delay"); // R22

    property p_latch_hold;
        @(posedge pclk) disable iff (!presetn)
        ((fault_q != '0) && !(wr && paddr == ADDR_CMD && pwdata[CMD_CLEAR]))
        |=> ((fault_q & $past(fault_q)) == $past(fault_q));
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("fault latch dropped"); // R03
endmodule : supply_output_protection_control

// File: supply_load_model.sv
// Load model that turns the applied current code into a measured current.
`timescale 1ns/10ps
module supply_load_model (
    input wire logic supply_on,
    input wire logic [15:0] amp_program,
    input wire logic [15:0] extra,
    output logic [15:0] meas_amp
);
    // A switched-off output carries no current, so an overload ends when the output trips.
    assign meas_amp = supply_on ? amp_program + extra : 16'h0000;
endmodule : supply_load_model

// File: supply_output_protection_control_tb_top.sv
// Self-checking testbench for the supply output protection controller.
`timescale 1ns/10ps
module supply_output_protection_control_tb_top;
    import supply_prot_pkg::*;
    localparam logic [15:0] RATED = 16'h03e8;
    localparam int AMAX = RATED * AMP_SET_PCT / PCT_BASE;
    localparam int TMAX = RATED * THR_MAX_PCT / PCT_BASE;
    localparam int TMIN = RATED * THR_MIN_PCT / PCT_BASE;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic supply_on;
    logic [1:0] priority_mode;
    logic [15:0] amp_program;
    logic [15:0] volt_program;
    logic [15:0] meas_amp;
    logic [3:0] pins = 4'h0;
    logic [15:0] extra = 16'h0;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    logic [31:0] v;
    int err_count = 0;
    int check_count = 0;
    int pin_bit[4] = '{F_OV, F_OP, F_OT, F_AC};

    supply_output_protection_control #(.RATED_AMP(RATED), .CYC_MS(10)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ov_cond(pins[0]), .op_cond(pins[1]), .ot_cond(pins[2]), .ac_fail_cond(pins[3]),
        .meas_amp(meas_amp), .supply_on(supply_on), .priority_mode(priority_mode),
        .amp_program(amp_program), .volt_program(volt_program)
    );
    supply_load_model i_load (
        .supply_on(supply_on), .amp_program(amp_program), .extra(extra), .meas_amp(meas_amp)
    );

    initial begin
        forever #2 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        check_count++;
        if (got !== want) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, want);
        end
    endtask : chk

    // Every completed transfer retires the oldest expectation.
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                e = exp_q.pop_front();
                chk({31'h0, pslverr}, {31'h0, e[32]});
                if (e[33]) begin
                    chk(prdata, e[31:0]);
                end
            end
        end
    end

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [32:0] r);
        int n;
        n = 0;
        exp_q.push_back({~w, r});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk(32'h0, 32'h1);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err = 1'b0);
        xfer(1'b1, a, d, {err, 32'h0});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic err = 1'b0);
        xfer(1'b0, a, 32'h0, {err, d});
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask : idle

    function automatic logic [31:0] st(input logic on, input logic wt, input logic [4:0] f);
        return (32'h1 << ST_SRC_BUS) | ({31'h0, on} << ST_ON) | ({31'h0, wt} << ST_WAIT)
            | ({27'h0, f} << ST_FAULT_LO);
    endfunction : st

    function automatic logic [31:0] ctl(input logic en, input logic [1:0] pr, input logic g,
                                        input logic s, input logic c);
        return ({31'h0, en} << CTRL_ENABLE) | ({30'h0, pr} << CTRL_PRIO_LO)
            | ({31'h0, g} << CTRL_GUARD) | ({31'h0, s} << CTRL_STEP) | ({31'h0, c} << CTRL_CONT);
    endfunction : ctl

    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #200000;
        err_count++;
        wrap_up;
    end

    initial begin
        void'($urandom(32'h60869255));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_OC_THRESH, TMAX);
        rd(ADDR_OC_DELAY, DELAY_MIN_MS);
        rd(ADDR_STATUS, st(1'b0, 1'b0, 5'h0));
        rd(8'h28, 32'h0, 1'b1);
        rd(8'h02, 32'h0, 1'b1);
        for (int p = 0; p < 3; p++) begin
            wr(ADDR_CTRL, ctl(1'b0, p[1:0], 1'b0, 1'b0, 1'b0));
            rd(ADDR_CTRL, ctl(1'b0, p[1:0], 1'b0, 1'b0, 1'b0));
            chk({30'h0, priority_mode}, p);
        end
        wr(ADDR_CTRL, ctl(1'b0, 2'b11, 1'b0, 1'b0, 1'b0), 1'b1);
        rd(ADDR_CTRL, ctl(1'b0, 2'b10, 1'b0, 1'b0, 1'b0));
        v = $urandom % (AMAX + 1);
        wr(ADDR_AMP_SET, v);
        rd(ADDR_AMP_SET, v);
        wr(ADDR_AMP_SET, AMAX);
        wr(ADDR_AMP_SET, AMAX + 1, 1'b1);
        rd(ADDR_AMP_SET, AMAX);
        wr(ADDR_TRIG_AMP, AMAX + 1, 1'b1);
        wr(ADDR_OC_THRESH, TMAX + 1, 1'b1);
        rd(ADDR_OC_THRESH, TMAX);
        wr(ADDR_CMD, 32'h1 << CMD_THR_MIN);
        rd(ADDR_OC_THRESH, TMIN);
        wr(ADDR_CMD, 32'h1 << CMD_RESET);
        rd(ADDR_OC_THRESH, TMAX);
        rd(ADDR_CMD, 32'h0);
        wr(ADDR_OC_DELAY, DELAY_MIN_MS - 1, 1'b1);
        wr(ADDR_OC_DELAY, DELAY_MAX_MS);
        rd(ADDR_OC_DELAY, DELAY_MAX_MS);
        wr(ADDR_OC_DELAY, DELAY_MIN_MS);
        wr(ADDR_CTRL, ctl(1'b1, 2'b00, 1'b0, 1'b0, 1'b0));
        wr(ADDR_AMP_SET, 32'h190);
        rd(ADDR_OUT_AMP, 32'h190);
        rd(ADDR_STATUS, st(1'b1, 1'b0, 5'h0));
        chk({31'h0, supply_on}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            pins[i] <= 1'b1;
            idle(6);
            wr(ADDR_CMD, 32'h1 << CMD_CLEAR);
            rd(ADDR_STATUS, st(1'b0, 1'b0, 5'h1 << pin_bit[i]));
            pins[i] <= 1'b0;
            idle(6);
            rd(ADDR_STATUS, st(1'b0, 1'b0, 5'h1 << pin_bit[i]));
            wr(ADDR_CMD, 32'h1 << CMD_CLEAR);
            rd(ADDR_STATUS, st(1'b1, 1'b0, 5'h0));
        end
        // The trip needs 50 ms, which is 500 cycles at ten cycles per millisecond.
        wr(ADDR_OC_THRESH, 32'h258);
        wr(ADDR_CTRL, ctl(1'b1, 2'b00, 1'b1, 1'b0, 1'b0));
        rd(ADDR_CTRL, ctl(1'b1, 2'b00, 1'b1, 1'b0, 1'b0));
        extra <= 16'h12c;
        idle(400);
        extra <= 16'h0;
        idle(5);
        extra <= 16'h12c;
        idle(400);
        rd(ADDR_STATUS, st(1'b1, 1'b0, 5'h0));
        idle(120);
        rd(ADDR_STATUS, st(1'b0, 1'b0, 5'h1 << F_OC));
        chk({31'h0, supply_on}, 32'h0);
        extra <= 16'h0;
        wr(ADDR_CMD, 32'h1 << CMD_CLEAR);
        rd(ADDR_STATUS, st(1'b1, 1'b0, 5'h0));
        wr(ADDR_CTRL, ctl(1'b1, 2'b00, 1'b0, 1'b0, 1'b0));
        extra <= 16'h12c;
        idle(600);
        rd(ADDR_STATUS, st(1'b1, 1'b0, 5'h0));
        extra <= 16'h0;
        wr(ADDR_TRIG_AMP, 32'h12c);
        wr(ADDR_TRIG_VOLT, 32'h4d);
        wr(ADDR_CTRL, ctl(1'b1, 2'b00, 1'b0, 1'b1, 1'b0));
        wr(ADDR_AMP_SET, 32'hc8);
        rd(ADDR_OUT_AMP, 32'h190);
        wr(ADDR_CMD, 32'h1 << CMD_FIRE);
        rd(ADDR_OUT_AMP, 32'h190);
        rd(ADDR_OUT_VOLT, 32'h0);
        wr(ADDR_CMD, 32'h1 << CMD_INIT);
        rd(ADDR_STATUS, st(1'b1, 1'b1, 5'h0));
        wr(ADDR_CMD, 32'h1 << CMD_FIRE);
        rd(ADDR_OUT_AMP, 32'h12c);
        rd(ADDR_STATUS, st(1'b1, 1'b0, 5'h0));
        chk({16'h0, volt_program}, 32'h4d);
        chk({16'h0, amp_program}, 32'h12c);
        wr(ADDR_CTRL, ctl(1'b1, 2'b00, 1'b0, 1'b1, 1'b1));
        rd(ADDR_STATUS, st(1'b1, 1'b1, 5'h0));
        wr(ADDR_TRIG_AMP, 32'hfa);
        wr(ADDR_CMD, 32'h1 << CMD_FIRE);
        rd(ADDR_OUT_AMP, 32'hfa);
        rd(ADDR_STATUS, st(1'b1, 1'b1, 5'h0));
        idle(5);
        wrap_up;
    end
endmodule : supply_output_protection_control_tb_top
